// file: design/rsx_alu.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// combinational rotate and subtract unit
// ============================================================
module rsx_alu #(
    parameter int unsigned WIDTH = 8
) (
    // operation select
    input wire rsx_pkg::rsx_op_e op,
    // operands
    input wire logic [WIDTH-1:0] operand,
    input wire logic [WIDTH-1:0] acc,
    input wire logic carry_in,
    // results
    output logic [WIDTH-1:0] result,
    output logic carry_out,
    output logic digit_carry_out,
    output logic zero_out
);

    // the digit carry needs a full low nibble
    if (WIDTH < 5) begin : g_width_check
        $error("rsx_alu: WIDTH must be at least 5");
    end

    // operation results, carry defaults to pass-through, digit carry to 0
    always_comb begin
        result = acc;
        carry_out = carry_in;
        digit_carry_out = 1'h0;
        case (op)
            rsx_pkg::rsx_op_rotate_left_through_carry: begin
                // old top bit leaves into carry, carry enters bit 0
                {carry_out, result} = {operand, carry_in};
            end
            rsx_pkg::rsx_op_rotate_right_through_carry: begin
                // old bit 0 leaves into carry, carry enters top bit
                {result, carry_out} = {carry_in, operand};
            end
            rsx_pkg::rsx_op_subtract_from_literal: begin
                result = operand - acc;
                carry_out = (acc <= operand);
                digit_carry_out = (acc[3:0] <= operand[3:0]);
            end
            default: begin
                result = acc;
            end
        endcase
        zero_out = (result == '0);
    end

endmodule : rsx_alu
`default_nettype wire

// file: design/rsx_exec.sv
// Function
// - left rotate: shift up, old carry into bit 0, old top into carry
// - right rotate: shift down, old carry into top, old bit 0 to carry
// - rotate destination 0 writes accumulator, 1 writes file register
// - sleep pulses watchdog_clear high for one cycle
// - sleep clears power-down flag, sets time-out flag, others kept
// - after sleep the oscillator halts and execution stops
// - subtract: literal minus accumulator, 8-bit result to accumulator
`timescale 1ns/10ps
`default_nettype none
module rsx_exec #(
    parameter int unsigned ADDR_W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instruction decoder
    input wire logic exec_valid,
    input wire rsx_pkg::rsx_op_e exec_op,
    input wire logic exec_dest,
    input wire logic [7:0] exec_operand,
    output logic exec_ready,
    // core side results
    output logic [7:0] acc_value,
    output logic file_wr_en,
    output logic [7:0] file_wr_data,
    output logic watchdog_clear,
    output logic osc_run
);

    // ========================================================
    // elaboration checks
    // ========================================================
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_addr_check
        $error("rsx_exec: ADDR_W must lie between 4 and 32");
    end

    // ========================================================
    // address decode
    // ========================================================
    function automatic rsx_pkg::rsx_sel_e rsx_decode(
        input logic [ADDR_W-1:0] addr
    );
        logic [31:0] wide;
        wide = 32'(addr);
        if (wide == 32'(rsx_pkg::RSX_ACC_OFS)) begin
            rsx_decode = rsx_pkg::rsx_sel_acc;
        end else if (wide == 32'(rsx_pkg::RSX_FLAGS_OFS)) begin
            rsx_decode = rsx_pkg::rsx_sel_flags;
        end else if (wide == 32'(rsx_pkg::RSX_CTRL_OFS)) begin
            rsx_decode = rsx_pkg::rsx_sel_ctrl;
        end else begin
            rsx_decode = rsx_pkg::rsx_sel_none;
        end
    endfunction : rsx_decode

    // ========================================================
    // state and datapath unit
    // ========================================================
    rsx_pkg::rsx_state_s st_r;
    rsx_pkg::rsx_state_s st_nxt;
    rsx_pkg::rsx_sel_e sel;
    logic exec_go;
    logic apb_setup;
    logic apb_write;
    logic [7:0] alu_result;
    logic alu_carry;
    logic alu_digit;
    logic alu_zero;

    rsx_alu #(
        .WIDTH(8)
    ) u_alu (
        .op(exec_op),
        .operand(exec_operand),
        .acc(st_r.acc),
        .carry_in(st_r.carry_flag),
        .result(alu_result),
        .carry_out(alu_carry),
        .digit_carry_out(alu_digit),
        .zero_out(alu_zero)
    );

    // handshake terms, execution only while running
    assign sel = rsx_decode(paddr);
    assign exec_ready = (st_r.mode == rsx_pkg::rsx_mode_run);
    assign exec_go = exec_valid && exec_ready;
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;

    // next state: execution first, then apb access
    always_comb begin
        st_nxt = st_r;
        st_nxt.file_wr_en = 1'h0;
        st_nxt.watchdog_clear = 1'h0;
        // read data and error captured in the setup cycle
        if (apb_setup) begin
            st_nxt.prdata = 32'h0000_0000;
            st_nxt.pslverr = (sel == rsx_pkg::rsx_sel_none);
            if (!pwrite) begin
                case (sel)
                    rsx_pkg::rsx_sel_acc: begin
                        st_nxt.prdata[7:0] = st_r.acc;
                    end
                    rsx_pkg::rsx_sel_flags: begin
                        st_nxt.prdata[rsx_pkg::RSX_FLAG_CARRY] =
                            st_r.carry_flag;
                        st_nxt.prdata[rsx_pkg::RSX_FLAG_DIGIT] =
                            st_r.digit_carry_flag;
                        st_nxt.prdata[rsx_pkg::RSX_FLAG_ZERO] =
                            st_r.zero_flag;
                        st_nxt.prdata[rsx_pkg::RSX_FLAG_PWRDN] =
                            st_r.power_down_flag;
                        st_nxt.prdata[rsx_pkg::RSX_FLAG_TMOUT] =
                            st_r.time_out_flag;
                        st_nxt.prdata[rsx_pkg::RSX_FLAG_SLEEP] =
                            (st_r.mode == rsx_pkg::rsx_mode_sleep);
                    end
                    default: begin
                        st_nxt.prdata = 32'h0000_0000;
                    end
                endcase
            end
        end
        if (exec_go) begin
            case (exec_op)
                rsx_pkg::rsx_op_rotate_left_through_carry,
                rsx_pkg::rsx_op_rotate_right_through_carry: begin
                    st_nxt.carry_flag = alu_carry;
                    if (exec_dest) begin
                        st_nxt.file_wr_en = 1'h1;
                        st_nxt.file_wr_data = alu_result;
                    end else begin
                        st_nxt.acc = alu_result;
                    end
                end
                rsx_pkg::rsx_op_subtract_from_literal: begin
                    st_nxt.acc = alu_result;
                    st_nxt.carry_flag = alu_carry;
                    st_nxt.digit_carry_flag = alu_digit;
                    st_nxt.zero_flag = alu_zero;
                end
                default: begin
                    st_nxt.watchdog_clear = 1'h1;
                    st_nxt.power_down_flag = 1'h0;
                    st_nxt.time_out_flag = 1'h1;
                    st_nxt.mode = rsx_pkg::rsx_mode_sleep;
                end
            endcase
        end else if (apb_write) begin
            // software writes, lost to an execution in the same cycle
            case (sel)
                rsx_pkg::rsx_sel_acc: begin
                    st_nxt.acc = pwdata[7:0];
                end
                rsx_pkg::rsx_sel_flags: begin
                    st_nxt.carry_flag = pwdata[rsx_pkg::RSX_FLAG_CARRY];
                    st_nxt.digit_carry_flag =
                        pwdata[rsx_pkg::RSX_FLAG_DIGIT];
                    st_nxt.zero_flag = pwdata[rsx_pkg::RSX_FLAG_ZERO];
                end
                rsx_pkg::rsx_sel_ctrl: begin
                    if (pwdata[rsx_pkg::RSX_CTRL_WAKE]) begin
                        st_nxt.mode = rsx_pkg::rsx_mode_run;
                    end
                end
                default: begin
                    st_nxt.acc = st_r.acc;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.acc <= rsx_pkg::RSX_ACC_RST;
            st_r.carry_flag <= rsx_pkg::RSX_CARRY_RST;
            st_r.digit_carry_flag <= rsx_pkg::RSX_DIGIT_RST;
            st_r.zero_flag <= rsx_pkg::RSX_ZERO_RST;
            st_r.power_down_flag <= rsx_pkg::RSX_PWRDN_RST;
            st_r.time_out_flag <= rsx_pkg::RSX_TMOUT_RST;
            st_r.mode <= rsx_pkg::rsx_mode_run;
            st_r.prdata <= 32'h0000_0000;
            st_r.pslverr <= 1'h0;
            st_r.file_wr_en <= 1'h0;
            st_r.file_wr_data <= 8'h00;
            st_r.watchdog_clear <= 1'h0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ========================================================
    // outputs
    // ========================================================
    assign pready = psel && penable;
    assign prdata = st_r.prdata;
    assign pslverr = st_r.pslverr && psel && penable;
    assign acc_value = st_r.acc;
    assign file_wr_en = st_r.file_wr_en;
    assign file_wr_data = st_r.file_wr_data;
    assign watchdog_clear = st_r.watchdog_clear;
    assign osc_run = (st_r.mode == rsx_pkg::rsx_mode_run);

    // ========================================================
    // assertions
    // ========================================================
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic go_rl;
    logic go_rr;
    logic go_sub;
    logic go_slp;
    assign go_rl = exec_go &&
        exec_op == rsx_pkg::rsx_op_rotate_left_through_carry;
    assign go_rr = exec_go &&
        exec_op == rsx_pkg::rsx_op_rotate_right_through_carry;
    assign go_sub = exec_go &&
        exec_op == rsx_pkg::rsx_op_subtract_from_literal;
    assign go_slp = exec_go && exec_op == rsx_pkg::rsx_op_sleep;

    rot_left_a: assert property (
        go_rl && !exec_dest |=>
            acc_value == {$past(exec_operand[6:0]), $past(st_r.carry_flag)}
            && st_r.carry_flag == $past(exec_operand[7]))
        else $error("left rotate result or carry wrong");

    rot_right_a: assert property (
        go_rr && exec_dest |=>
            file_wr_data == {$past(st_r.carry_flag), $past(exec_operand[7:1])}
            && st_r.carry_flag == $past(exec_operand[0]))
        else $error("right rotate result or carry wrong");

    rot_dest_a: assert property (
        (go_rl || go_rr) |=>
            (file_wr_en == $past(exec_dest))
            && (!$past(exec_dest) || acc_value == $past(acc_value))
            ##1 (file_wr_en == ($past(go_rl || go_rr) && $past(exec_dest))))
        else $error("rotate destination wrong");

    wdog_clear_a: assert property (
        go_slp |=> watchdog_clear ##1 !watchdog_clear)
        else $error("watchdog clear pulse missing");

    wdog_cause_a: assert property (
        watchdog_clear |-> $past(go_slp))
        else $error("watchdog cleared without sleep");

    sleep_flags_a: assert property (
        go_slp |=> !st_r.power_down_flag && st_r.time_out_flag
            && $stable(st_r.carry_flag) && $stable(st_r.zero_flag)
            && $stable(st_r.digit_carry_flag))
        else $error("sleep status flags wrong");

    sleep_halt_a: assert property (
        go_slp |=> !osc_run && !exec_ready)
        else $error("oscillator still running after sleep");

    sleep_hold_a: assert property (
        !osc_run && exec_valid && !apb_write |=> $stable(acc_value)
            && !file_wr_en)
        else $error("execution while asleep");

    sub_result_a: assert property (
        go_sub |=> acc_value == 8'($past(exec_operand) - $past(acc_value)))
        else $error("subtract result wrong");

    sub_flags_a: assert property (
        go_sub |=>
            st_r.carry_flag == ($past(acc_value) <= $past(exec_operand))
            && st_r.digit_carry_flag ==
                ($past(acc_value[3:0]) <= $past(exec_operand[3:0]))
            && st_r.zero_flag == (acc_value == 8'h00))
        else $error("subtract flags wrong");

    rot_flags_a: assert property (
        (go_rl || go_rr) |=> $stable(st_r.zero_flag)
            && $stable(st_r.digit_carry_flag))
        else $error("rotate changed flags other than carry");

    apb_err_a: assert property (
        pready && sel == rsx_pkg::rsx_sel_none |-> pslverr)
        else $error("unmapped access answered without error");

    wake_run_a: assert property (
        apb_write && !exec_go && sel == rsx_pkg::rsx_sel_ctrl
            && pwdata[rsx_pkg::RSX_CTRL_WAKE] |=> osc_run)
        else $error("wake write did not restart execution");

    rot_left_c: cover property (go_rl ##1 go_rr);
    sub_zero_c: cover property (go_sub ##1 st_r.zero_flag);
    sleep_wake_c: cover property (go_slp ##[1:20] osc_run);
    sleep_refused_c: cover property (!osc_run && exec_valid);

endmodule : rsx_exec
`default_nettype wire

// file: pkg/rsx_pkg.sv
// ============================================================
// constants and types of the rotate/subtract/sleep datapath
// ============================================================
package rsx_pkg;

    // ========================================================
    // register offsets (byte addresses on the apb bus)
    // ========================================================
    localparam logic [7:0] RSX_ACC_OFS = 8'h00;
    localparam logic [7:0] RSX_FLAGS_OFS = 8'h04;
    localparam logic [7:0] RSX_CTRL_OFS = 8'h08;

    // ========================================================
    // field positions
    // ========================================================
    localparam int RSX_FLAG_CARRY = 0;
    localparam int RSX_FLAG_DIGIT = 1;
    localparam int RSX_FLAG_ZERO = 2;
    localparam int RSX_FLAG_PWRDN = 3;
    localparam int RSX_FLAG_TMOUT = 4;
    localparam int RSX_FLAG_SLEEP = 5;
    localparam int RSX_CTRL_WAKE = 0;

    // ========================================================
    // reset values
    // ========================================================
    localparam logic [7:0] RSX_ACC_RST = 8'h00;
    localparam logic RSX_CARRY_RST = 1'h0;
    localparam logic RSX_DIGIT_RST = 1'h0;
    localparam logic RSX_ZERO_RST = 1'h0;
    localparam logic RSX_PWRDN_RST = 1'h1;
    localparam logic RSX_TMOUT_RST = 1'h1;

    // ========================================================
    // operations issued by the decoder
    // ========================================================
    typedef enum logic [1:0] {
        rsx_op_rotate_left_through_carry = 2'h0,
        rsx_op_rotate_right_through_carry = 2'h1,
        rsx_op_subtract_from_literal = 2'h2,
        rsx_op_sleep = 2'h3
    } rsx_op_e;

    // core execution mode, gray along run -> sleep -> run
    typedef enum logic {
        rsx_mode_run = 1'h0,
        rsx_mode_sleep = 1'h1
    } rsx_mode_e;

    // register selected by an apb address
    typedef enum logic [1:0] {
        rsx_sel_acc = 2'h0,
        rsx_sel_flags = 2'h1,
        rsx_sel_ctrl = 2'h2,
        rsx_sel_none = 2'h3
    } rsx_sel_e;

    // whole state of the datapath
    typedef struct packed {
        logic [7:0] acc;
        logic carry_flag;
        logic digit_carry_flag;
        logic zero_flag;
        logic power_down_flag;
        logic time_out_flag;
        rsx_mode_e mode;
        logic [31:0] prdata;
        logic pslverr;
        logic file_wr_en;
        logic [7:0] file_wr_data;
        logic watchdog_clear;
    } rsx_state_s;

endpackage : rsx_pkg

// file: tb/tb_rsx_exec.sv
`timescale 1ns/10ps
`default_nettype none
module tb_rsx_exec;
    // ==================================================
    // signals and model state
    // ==================================================
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic exec_valid, exec_dest, exec_ready, file_wr_en;
    logic watchdog_clear, osc_run, err;
    rsx_pkg::rsx_op_e exec_op;
    logic [7:0] exec_operand, acc_value, file_wr_data;
    logic [7:0] m_acc, m_fwd;
    logic m_c, m_dc, m_z, m_pd, m_to, m_sl, m_fwe, m_wdc;
    int err_total, comparisons;

    rsx_exec uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .exec_valid(exec_valid),
        .exec_op(exec_op), .exec_dest(exec_dest),
        .exec_operand(exec_operand), .exec_ready(exec_ready),
        .acc_value(acc_value), .file_wr_en(file_wr_en),
        .file_wr_data(file_wr_data), .watchdog_clear(watchdog_clear),
        .osc_run(osc_run)
    );

    // clock of 10 ns
    always #5 pclk = ~pclk;

    // ==================================================
    // shared tasks
    // ==================================================
    // compare and count
    task automatic chk(input logic [31:0] seen, exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one apb transfer, waits for pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        chk(32'(n < 50), 32'h1, "pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // expected flags word
    function automatic logic [31:0] flags_exp();
        return 32'({m_sl, m_to, m_pd, m_z, m_dc, m_c});
    endfunction : flags_exp

    // read flags and compare with the model
    task automatic chk_flags();
        apb(1'h0, rsx_pkg::RSX_FLAGS_OFS, 32'h0);
        chk(rd, flags_exp(), "flags");
    endtask : chk_flags

    // drive one decoder slot, check the slot before, then model it
    task automatic exec(input logic v, input rsx_pkg::rsx_op_e op,
                        input logic d, input logic [7:0] k);
        logic [7:0] r;
        @(posedge pclk);
        exec_valid <= v;
        exec_op <= op;
        exec_dest <= d;
        exec_operand <= k;
        @(negedge pclk);
        chk(32'(acc_value), 32'(m_acc), "acc");
        chk(32'(file_wr_en), 32'(m_fwe), "file_wr_en");
        chk(32'(file_wr_data), 32'(m_fwd), "file_wr_data");
        chk(32'(watchdog_clear), 32'(m_wdc), "wdog");
        chk(32'(osc_run), 32'(!m_sl), "osc_run");
        chk(32'(exec_ready), 32'(!m_sl), "exec_ready");
        m_fwe = 1'h0;
        m_wdc = 1'h0;
        if (v && !m_sl) begin
            r = 8'h00;
            case (op)
                rsx_pkg::rsx_op_rotate_left_through_carry: begin
                    r = {k[6:0], m_c};
                    m_c = k[7];
                end
                rsx_pkg::rsx_op_rotate_right_through_carry: begin
                    r = {m_c, k[7:1]};
                    m_c = k[0];
                end
                rsx_pkg::rsx_op_subtract_from_literal: begin
                    r = k - m_acc;
                    m_c = (m_acc <= k);
                    m_dc = (m_acc[3:0] <= k[3:0]);
                    m_z = (r == 8'h00);
                    m_acc = r;
                end
                default: begin
                    m_wdc = 1'h1;
                    m_pd = 1'h0;
                    m_to = 1'h1;
                    m_sl = 1'h1;
                end
            endcase
            if (op inside {rsx_pkg::rsx_op_rotate_left_through_carry,
                           rsx_pkg::rsx_op_rotate_right_through_carry}) begin
                if (d) begin
                    m_fwe = 1'h1;
                    m_fwd = r;
                end else begin
                    m_acc = r;
                end
            end
        end
    endtask : exec

    // counts and verdict
    task automatic print_verdict();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // ==================================================
    // main sequence
    // ==================================================
    initial begin
        pclk = 1'h0;
        presetn = 1'h0;
        {psel, penable, pwrite, exec_valid, exec_dest} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        exec_op = rsx_pkg::rsx_op_rotate_left_through_carry;
        exec_operand = 8'h00;
        {m_acc, m_fwd, m_c, m_dc, m_z, m_sl, m_fwe, m_wdc} = 22'h0;
        {m_pd, m_to} = 2'h3;
        err_total = 0;
        comparisons = 0;
        void'($urandom(32'h079a));
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        // reset values and an unmapped read
        chk_flags();
        apb(1'h0, 8'h0C, 32'h0);
        chk({31'h0, err}, 32'h1, "pslverr");
        chk(rd, 32'h0, "unmapped data");
        // read-only flag bits ignore writes
        apb(1'h1, rsx_pkg::RSX_FLAGS_OFS, 32'h3F);
        {m_z, m_dc, m_c} = 3'h7;
        chk_flags();
        apb(1'h1, rsx_pkg::RSX_FLAGS_OFS, 32'h0);
        {m_z, m_dc, m_c} = 3'h0;
        apb(1'h1, rsx_pkg::RSX_ACC_OFS, 32'h5A);
        m_acc = 8'h5A;
        // accumulator and control read back over the bus
        apb(1'h0, rsx_pkg::RSX_ACC_OFS, 32'h0);
        chk(rd, 32'(m_acc), "acc read");
        chk({31'h0, err}, 32'h0, "pslverr mapped");
        apb(1'h0, rsx_pkg::RSX_CTRL_OFS, 32'h0);
        chk(rd, 32'h0, "ctrl read");
        // worked rotate, then subtract corners back to back
        exec(1'h1, rsx_pkg::rsx_op_rotate_left_through_carry, 1'h0, 8'hE6);
        exec(1'h1, rsx_pkg::rsx_op_subtract_from_literal, 1'h0, 8'hCC);
        exec(1'h1, rsx_pkg::rsx_op_rotate_right_through_carry, 1'h1, 8'h01);
        exec(1'h1, rsx_pkg::rsx_op_subtract_from_literal, 1'h0, 8'h00);
        exec(1'h0, rsx_pkg::rsx_op_subtract_from_literal, 1'h0, 8'h00);
        chk_flags();
        // random traffic with idle slots
        for (int i = 0; i < 300; i++) begin
            exec(1'($urandom % 4 != 0),
                 rsx_pkg::rsx_op_e'($urandom % 3), 1'($urandom),
                 8'($urandom));
            if (i % 60 == 59) begin
                exec(1'h0, rsx_pkg::rsx_op_sleep, 1'h0, 8'h00);
                chk_flags();
            end
        end
        // sleep, refused request while asleep, then wake
        exec(1'h1, rsx_pkg::rsx_op_sleep, 1'h0, 8'h00);
        exec(1'h1, rsx_pkg::rsx_op_rotate_left_through_carry, 1'h1, 8'h81);
        exec(1'h0, rsx_pkg::rsx_op_sleep, 1'h0, 8'h00);
        exec(1'h0, rsx_pkg::rsx_op_sleep, 1'h0, 8'h00);
        chk_flags();
        apb(1'h1, rsx_pkg::RSX_CTRL_OFS, 32'h1);
        m_sl = 1'h0;
        exec(1'h1, rsx_pkg::rsx_op_rotate_right_through_carry, 1'h0, 8'h81);
        exec(1'h0, rsx_pkg::rsx_op_sleep, 1'h0, 8'h00);
        chk_flags();
        print_verdict();
    end

    // watchdog against a hang
    initial begin
        #100000;
        err_total++;
        print_verdict();
    end
endmodule : tb_rsx_exec
`default_nettype wire
